// >>> cfgprg_pkg.sv
// constants for the configuration eeprom programmer
package cfgprg_pkg;
    localparam logic [15:0] CFGPRG_ADDR_PROG_CTRL = 16'h103B;
    localparam logic [15:0] CFGPRG_ADDR_NV_CONFIG = 16'h103F;
    localparam int          CFGPRG_BIT_PGM        = 0;
    localparam int          CFGPRG_BIT_LAT        = 1;
    localparam int          CFGPRG_BIT_ERASE      = 2;
    localparam int          CFGPRG_BIT_EE_ENABLE  = 0;
    localparam int          CFGPRG_BIT_NOWD       = 2;
    localparam int          CFGPRG_BIT_SEC        = 3;
    localparam logic [7:0]  CFGPRG_ERASED         = 8'hFF;
    localparam logic [7:0]  CFGPRG_PROG_RESET     = 8'h00;
    localparam logic [7:0]  CFGPRG_CFG_DEFAULT    = 8'h0F;
    localparam logic [1:0]  CFGPRG_MODE_SCHIP     = 2'h0;
    localparam logic [1:0]  CFGPRG_MODE_EXP       = 2'h1;
    localparam logic [1:0]  CFGPRG_MODE_BOOT      = 2'h2;
    localparam logic [1:0]  CFGPRG_MODE_TEST      = 2'h3;
    localparam int          CFGPRG_MEM_ERASE_CYC  = 16;
    localparam logic [3:0]  CFGPRG_MEM_ERASE_LAST = 4'hF;
endpackage

// >>> cfgprg_core.sv
// configuration eeprom programmer: control register, latches, reset mode and strobe pin
// Notes on behaviour
// - programming accepted only in special bootstrap or special test mode
// - eeprom enable bit zero disables eeprom; upper nibble places it
// - watchdog enabled when watchdog disable bit is zero
// - internal rom reads return rom data, ignoring external bus
// - clearing control register ends erase or write
// - stored value copied to working register only at reset
// - secured device enters only single-chip modes
// - secured with mode b low enters bootstrap, ignoring mode a
// - secured bootstrap reset erases eeprom and configuration
// - unsecured expanded reset toggles address strobe even in reset
// - secured: address strobe is high-impedance input, no toggle
// - secured bootstrap erases eeprom and ram first, then configuration
`timescale 1ns/10ps
`default_nettype none
module cfgprg_core
    import cfgprg_pkg::*;
(
    input  wire logic        mclk_in,
    input  wire logic        resetn_in,
    input  wire logic        ce_in,
    input  wire logic [15:0] addr_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [7:0]  rdata_out,
    input  wire logic        mode_select_a_in,
    input  wire logic        mode_select_b_in,
    input  wire logic        rom_hit_in,
    input  wire logic [7:0]  rom_data_in,
    input  wire logic [7:0]  ext_data_in,
    output logic      [7:0]  cpu_data_out,
    output logic      [1:0]  mode_out,
    output logic             eeprom_on_out,
    output logic      [3:0]  eeprom_page_out,
    output logic             watchdog_on_out,
    output logic             secured_out,
    output logic             mem_erase_out,
    output logic             address_strobe_pin_out,
    output logic             address_strobe_pin_oe_out,
    output logic             pump_on_out
);
    typedef enum {CFGPRG_ST_IDLE, CFGPRG_ST_MEM, CFGPRG_ST_CFG, CFGPRG_ST_RUN} cfgprg_st_e;

    cfgprg_st_e  st;
    logic [7:0]  nv_cell = CFGPRG_ERASED; // cells leave the factory erased
    logic [7:0]  working;
    logic [7:0]  eeprom_program_control;
    logic [7:0]  latch_data;
    logic        latch_valid;
    logic [3:0]  erase_cnt;
    logic        special;
    logic        wr_ctrl;
    logic        wr_cfg;
    logic        sec_stored;
    logic [1:0]  next_mode;

    assign sec_stored = ~nv_cell[CFGPRG_BIT_SEC];
    assign special    = (mode_out == CFGPRG_MODE_BOOT) || (mode_out == CFGPRG_MODE_TEST);
    assign wr_ctrl    = ce_in && wr_in && (addr_in == CFGPRG_ADDR_PROG_CTRL);
    assign wr_cfg     = ce_in && wr_in && (addr_in == CFGPRG_ADDR_NV_CONFIG);

    // reset mode from pins; security forces single-chip family
    always_comb begin
        if (sec_stored) begin
            next_mode = mode_select_b_in ? CFGPRG_MODE_SCHIP : CFGPRG_MODE_BOOT;
        end else begin
            next_mode = {~mode_select_b_in, mode_select_a_in};
        end
    end

    // mode is sampled on each clock while reset is held; no reset of its own, it keeps its value after release
    always_ff @(posedge mclk_in) begin
        if (!resetn_in && ce_in) begin
            mode_out <= next_mode;
        end
    end

    // sequencer after reset: optional secured erase, then load working value
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st        <= CFGPRG_ST_IDLE;
            erase_cnt <= 4'h0;
        end else if (ce_in) begin
            case (st)
                CFGPRG_ST_IDLE: begin
                    st <= (sec_stored && mode_out == CFGPRG_MODE_BOOT) ? CFGPRG_ST_MEM
                                                                       : CFGPRG_ST_CFG;
                end
                CFGPRG_ST_MEM: begin
                    erase_cnt <= erase_cnt + 4'h1;
                    if (erase_cnt == CFGPRG_MEM_ERASE_LAST) begin
                        st <= CFGPRG_ST_CFG;
                    end
                end
                CFGPRG_ST_CFG: st <= CFGPRG_ST_RUN;
                CFGPRG_ST_RUN: st <= CFGPRG_ST_RUN;
                default:       st <= CFGPRG_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mem_erase_out <= 1'b0;
        end else if (ce_in) begin
            mem_erase_out <= (st == CFGPRG_ST_MEM) && (erase_cnt != CFGPRG_MEM_ERASE_LAST);
        end
    end

    // control register; writes refused outside special modes
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            eeprom_program_control <= CFGPRG_PROG_RESET;
        end else if (ce_in && wr_ctrl && special && st == CFGPRG_ST_RUN) begin
            eeprom_program_control <= wdata_in;
        end
    end

    // programming latches capture config writes while latch bit set and program bit clear
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            latch_data  <= CFGPRG_ERASED;
            latch_valid <= 1'b0;
        end else if (ce_in) begin
            if (!eeprom_program_control[CFGPRG_BIT_LAT]) begin
                latch_valid <= 1'b0;
            end else if (wr_cfg && !eeprom_program_control[CFGPRG_BIT_PGM]) begin
                latch_data  <= wdata_in;
                latch_valid <= 1'b1;
            end
        end
    end

    // nonvolatile cell: no reset, it survives reset by nature
    // erase drives all ones; a write can only clear bits, as a real cell does
    always_ff @(posedge mclk_in) begin
        if (ce_in) begin
            // wiped on the last erase step, so the load that follows sees ones
            if (st == CFGPRG_ST_MEM && erase_cnt == CFGPRG_MEM_ERASE_LAST) begin
                nv_cell <= CFGPRG_ERASED;
            end else if (eeprom_program_control[CFGPRG_BIT_PGM] && latch_valid) begin
                if (eeprom_program_control[CFGPRG_BIT_ERASE]) begin
                    nv_cell <= CFGPRG_ERASED;
                end else begin
                    nv_cell <= nv_cell & latch_data;
                end
            end
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pump_on_out <= 1'b0;
        end else if (ce_in) begin
            pump_on_out <= eeprom_program_control[CFGPRG_BIT_PGM];
        end
    end

    // working copy loaded once per reset
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            working <= CFGPRG_CFG_DEFAULT;
        end else if (ce_in && st == CFGPRG_ST_CFG) begin
            working <= nv_cell;
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            eeprom_on_out   <= 1'b0;
            eeprom_page_out <= 4'h0;
            watchdog_on_out <= 1'b0;
            secured_out     <= 1'b0;
        end else if (ce_in) begin
            eeprom_on_out   <= working[CFGPRG_BIT_EE_ENABLE];
            eeprom_page_out <= working[7:4];
            watchdog_on_out <= ~working[CFGPRG_BIT_NOWD];
            secured_out     <= ~working[CFGPRG_BIT_SEC];
        end
    end

    // address strobe toggles during reset too, hence no reset on it
    always_ff @(posedge mclk_in) begin
        if (ce_in) begin
            if (!sec_stored && mode_out == CFGPRG_MODE_EXP) begin
                address_strobe_pin_out    <= ~address_strobe_pin_out;
                address_strobe_pin_oe_out <= 1'b1;
            end else begin
                address_strobe_pin_out    <= 1'b0;
                address_strobe_pin_oe_out <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cpu_data_out <= 8'h00;
        end else if (ce_in) begin
            cpu_data_out <= rom_hit_in ? rom_data_in : ext_data_in;
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdata_out <= 8'h00;
        end else if (ce_in) begin
            if (rd_in && addr_in == CFGPRG_ADDR_PROG_CTRL) begin
                rdata_out <= eeprom_program_control;
            end else if (rd_in && addr_in == CFGPRG_ADDR_NV_CONFIG) begin
                rdata_out <= working;
            end else begin
                rdata_out <= 8'h00;
            end
        end
    end

    AST_REFUSE_NORMAL: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (ce_in && wr_ctrl && !special) |=> $stable(eeprom_program_control))
        else $error("control written in normal mode");

    AST_PUMP_OFF: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (ce_in && wr_ctrl && special && st == CFGPRG_ST_RUN && wdata_in == 8'h00)
            |=> ##1 !pump_on_out)
        else $error("pump stays on after clear");

    AST_WORKING_HOLD: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (st == CFGPRG_ST_RUN && $past(st) == CFGPRG_ST_RUN) |-> $stable(working))
        else $error("working value changed after reset");

    AST_WATCHDOG: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (ce_in && $past(ce_in)) |-> ##0 (watchdog_on_out == ~$past(working[CFGPRG_BIT_NOWD])))
        else $error("watchdog enable wrong");

    AST_EEPROM_PAGE: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        ce_in |=> (eeprom_page_out == $past(working[7:4]) || !$past(ce_in)))
        else $error("eeprom page wrong");

    AST_SECURE_MODE: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        secured_out |-> (mode_out == CFGPRG_MODE_SCHIP || mode_out == CFGPRG_MODE_BOOT))
        else $error("secured part in expanded mode");

    AST_STROBE_QUIET: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        secured_out |-> !address_strobe_pin_oe_out)
        else $error("strobe driven while secured");

    AST_ROM_DATA: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (ce_in && rom_hit_in) |=> (cpu_data_out == $past(rom_data_in)))
        else $error("rom data not returned");

    AST_LATCH: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (ce_in && wr_cfg && eeprom_program_control[CFGPRG_BIT_LAT]
            && !eeprom_program_control[CFGPRG_BIT_PGM]) |=> (latch_data == $past(wdata_in)))
        else $error("latch did not capture");

    AST_BOOT_ERASE: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (ce_in && st == CFGPRG_ST_MEM && erase_cnt == CFGPRG_MEM_ERASE_LAST)
            |=> (nv_cell == CFGPRG_ERASED))
        else $error("secured boot did not erase");

    AST_STROBE_TOGGLE: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (ce_in && !sec_stored && mode_out == CFGPRG_MODE_EXP)
            |=> (address_strobe_pin_oe_out
                 && address_strobe_pin_out != $past(address_strobe_pin_out)))
        else $error("strobe not toggling");

    AST_MEM_BEFORE_CFG: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (st == CFGPRG_ST_CFG) |-> !mem_erase_out)
        else $error("memory erase still running at config load");

    AST_ERASE_PULSE: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (ce_in && st == CFGPRG_ST_MEM && erase_cnt == 4'h0) |=> mem_erase_out)
        else $error("memory erase did not start");

    AST_LATCH_FROZEN: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (ce_in && eeprom_program_control[CFGPRG_BIT_PGM]) |=> $stable(latch_data))
        else $error("latch changed while programming");

    AST_WORKING_LOAD: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (ce_in && st == CFGPRG_ST_CFG) |=> (working == $past(nv_cell)))
        else $error("working value not loaded from cell");

    AST_CTRL_LOAD: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (wr_ctrl && special && st == CFGPRG_ST_RUN)
            |=> (eeprom_program_control == $past(wdata_in)))
        else $error("control write lost in special mode");

    AST_NV_HOLD: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (ce_in && st == CFGPRG_ST_RUN && !eeprom_program_control[CFGPRG_BIT_PGM])
            |=> $stable(nv_cell))
        else $error("cell changed with programming off");

    AST_MODE_HOLD: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (st == CFGPRG_ST_RUN) |-> $stable(mode_out))
        else $error("mode changed outside reset");
endmodule // cfgprg_core
`default_nettype wire

// >>> tb_top.sv
// self-checking testbench for the configuration eeprom programmer
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import cfgprg_pkg::*;
;
    logic        mclk_in = 1'b0;
    logic        resetn_in = 1'b0;
    logic        ce_in = 1'b1;
    logic [15:0] addr_in = 16'h0000;
    logic [7:0]  wdata_in = 8'h00;
    logic        wr_in = 1'b0;
    logic        rd_in = 1'b0;
    logic [7:0]  rdata_out;
    logic        mode_select_a_in = 1'b1;
    logic        mode_select_b_in = 1'b0;
    logic        rom_hit_in = 1'b0;
    logic [7:0]  rom_data_in = 8'h00;
    logic [7:0]  ext_data_in = 8'h00;
    logic [7:0]  cpu_data_out;
    logic [1:0]  mode_out;
    logic        eeprom_on_out;
    logic [3:0]  eeprom_page_out;
    logic        watchdog_on_out;
    logic        secured_out;
    logic        mem_erase_out;
    logic        address_strobe_pin_out;
    logic        address_strobe_pin_oe_out;
    logic        pump_on_out;
    int          n_mismatch = 0;
    int          n_tests = 0;

    always #2.5 mclk_in = ~mclk_in;

    cfgprg_core cfgprg_core_i (.mclk_in(mclk_in), .resetn_in(resetn_in), .ce_in(ce_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .mode_select_a_in(mode_select_a_in),
        .mode_select_b_in(mode_select_b_in), .rom_hit_in(rom_hit_in),
        .rom_data_in(rom_data_in), .ext_data_in(ext_data_in), .cpu_data_out(cpu_data_out),
        .mode_out(mode_out), .eeprom_on_out(eeprom_on_out), .eeprom_page_out(eeprom_page_out),
        .watchdog_on_out(watchdog_on_out), .secured_out(secured_out),
        .mem_erase_out(mem_erase_out), .address_strobe_pin_out(address_strobe_pin_out),
        .address_strobe_pin_oe_out(address_strobe_pin_oe_out), .pump_on_out(pump_on_out));

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge mclk_in);
        wr_in <= 1'b0;
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        @(posedge mclk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1 chk("rdata", exp, rdata_out);
    endtask

    // reset with the mode pins set; the strobe is watched while reset is still low
    task automatic do_reset(input logic b, input logic a, input logic tog, input logic me);
        logic s;
        @(posedge mclk_in);
        mode_select_b_in <= b;
        mode_select_a_in <= a;
        resetn_in <= 1'b0;
        repeat (9) @(posedge mclk_in);
        #1 s = address_strobe_pin_out;
        @(posedge mclk_in);
        #1 chk("strobe_oe", {7'h00, tog}, {7'h00, address_strobe_pin_oe_out});
        if (tog) chk("strobe", {7'h00, ~s}, {7'h00, address_strobe_pin_out});
        @(posedge mclk_in);
        resetn_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        #1 chk("mem_erase", {7'h00, me}, {7'h00, mem_erase_out});
        repeat (40) @(posedge mclk_in);
    endtask

    // erase then program; the pulse is shortened since the design has no timer
    task automatic erase_prog(input logic [7:0] v, input logic ok);
        wr(CFGPRG_ADDR_PROG_CTRL, 8'h06);
        wr(CFGPRG_ADDR_NV_CONFIG, 8'h00);
        wr(CFGPRG_ADDR_PROG_CTRL, 8'h07);
        repeat (2) @(posedge mclk_in);
        #1 chk("pump_on", {7'h00, ok}, {7'h00, pump_on_out});
        repeat (4) @(posedge mclk_in);
        wr(CFGPRG_ADDR_PROG_CTRL, 8'h00);
        repeat (2) @(posedge mclk_in);
        #1 chk("pump_off", 8'h00, {7'h00, pump_on_out});
        wr(CFGPRG_ADDR_PROG_CTRL, 8'h02);
        wr(CFGPRG_ADDR_NV_CONFIG, v);
        wr(CFGPRG_ADDR_PROG_CTRL, 8'h03);
        repeat (6) @(posedge mclk_in);
        wr(CFGPRG_ADDR_PROG_CTRL, 8'h00);
    endtask

    task automatic check_cfg(input logic [1:0] m, input logic [7:0] v);
        #1 chk("mode", {6'h00, m}, {6'h00, mode_out});
        chk("eeprom_on", {7'h00, v[0]}, {7'h00, eeprom_on_out});
        chk("page", {4'h0, v[7:4]}, {4'h0, eeprom_page_out});
        chk("watchdog", {7'h00, ~v[2]}, {7'h00, watchdog_on_out});
        chk("secured", {7'h00, ~v[3]}, {7'h00, secured_out});
        rd_chk(CFGPRG_ADDR_NV_CONFIG, v);
    endtask

    task automatic rom_mux;
        @(posedge mclk_in);
        rom_hit_in <= 1'b1;
        rom_data_in <= 8'hA5;
        ext_data_in <= 8'h5A;
        repeat (2) @(posedge mclk_in);
        #1 chk("cpu_data_rom", 8'hA5, cpu_data_out);
        @(posedge mclk_in);
        rom_hit_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        #1 chk("cpu_data_ext", 8'h5A, cpu_data_out);
    endtask

    // enable low must hold every flop; the running strobe makes that visible
    task automatic freeze_chk;
        logic s;
        @(posedge mclk_in);
        ce_in <= 1'b0;
        @(posedge mclk_in);
        #1 s = address_strobe_pin_out;
        @(posedge mclk_in);
        #1 chk("strobe_held", {7'h00, s}, {7'h00, address_strobe_pin_out});
        @(posedge mclk_in);
        ce_in <= 1'b1;
        @(posedge mclk_in);
        #1 chk("strobe_runs", {7'h00, ~s}, {7'h00, address_strobe_pin_out});
    endtask

    // read first and rewrite only on a difference, to spare the cells
    task automatic update_cfg(input logic [7:0] v);
        @(posedge mclk_in);
        rd_in <= 1'b1;
        addr_in <= CFGPRG_ADDR_NV_CONFIG;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1;
        if (rdata_out !== v) erase_prog(v, 1'b1);
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        #50000;
        n_mismatch++;
        wrap_up();
    end

    initial begin
        do_reset(1'b0, 1'b1, 1'b0, 1'b0);
        erase_prog(8'h2E, 1'b1);
        do_reset(1'b0, 1'b1, 1'b0, 1'b0);
        check_cfg(CFGPRG_MODE_TEST, 8'h2E);
        erase_prog(8'h1B, 1'b1);
        rd_chk(CFGPRG_ADDR_NV_CONFIG, 8'h2E);
        do_reset(1'b1, 1'b1, 1'b1, 1'b0);
        check_cfg(CFGPRG_MODE_EXP, 8'h1B);
        rom_mux();
        freeze_chk();
        erase_prog(8'h00, 1'b0);
        do_reset(1'b0, 1'b1, 1'b0, 1'b0);
        check_cfg(CFGPRG_MODE_TEST, 8'h1B);
        update_cfg(8'h17);
        do_reset(1'b1, 1'b1, 1'b0, 1'b0);
        check_cfg(CFGPRG_MODE_SCHIP, 8'h17);
        do_reset(1'b0, 1'b1, 1'b0, 1'b1);
        check_cfg(CFGPRG_MODE_BOOT, CFGPRG_ERASED);
        wrap_up();
    end
endmodule // tb_top
`default_nettype wire
